// ### fcor_regs.sv
/*
  Floppy configuration option register group: option control, drive type
  store, reserved-zero and drive-0 configuration, over a Wishbone classic slave.
  Assumes word addressing (byte address = 4 * index) and one 50 MHz clock.
*/
`timescale 1ns/1ps
module fcor_regs (
  input wire logic clk_i, // Clock, 50 MHz
  input wire logic rst_i, // Sync reset, high
  // Wishbone classic slave
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [fcor_pkg::ADDR_W-1:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  // Drive side
  input wire logic disable_wp_i, // Device-disable write-protect bit
  input fcor_pkg::fcor_drive_pins_t fdd_pins_i, // Dedicated drive pins
  input fcor_pkg::fcor_drive_pins_t pport_pins_i, // Parallel-port floppy pins
  input wire logic core_density_i, // Core density request
  output logic core_wp_o, // Write protect to core, dedicated path
  output logic pport_wp_o, // Write protect to core, parallel-port path
  output logic status_register_a_wp_o, // Status register A bit 1
  output logic density_o, // Density pin level
  output logic [1:0] drive_b_type_o, // Stored drive B type
  output fcor_pkg::fcor_drive0_cfg_t drive0_cfg_o // Drive-0 settings
);

  // ==========================================================
  // Storage
  logic [7:0] option_reg;
  logic [7:0] type_reg;
  logic [7:0] drv0_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] rdata_next;
  logic req;
  logic wr_en;
  logic [7:0] idx;
  logic core_wp_int;
  logic ack_edge;
  logic hit_option;
  logic hit_type;
  logic hit_zero;
  logic hit_drv0;

  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  // A write lands at the edge where the master samples ack, not at the taking
  // edge, so a cycle dropped before its answer leaves the registers alone
  assign ack_edge = wb_cyc_i & wb_stb_i & ack_reg;
  assign wr_en = ack_edge & wb_we_i & wb_sel_i[0];
  // Low two address bits ignored: word aligned registers
  assign idx = wb_adr_i[9:2];
  assign hit_option = (idx == fcor_pkg::IDX_OPTION);
  assign hit_type = (idx == fcor_pkg::IDX_TYPE);
  assign hit_zero = (idx == fcor_pkg::IDX_ZERO);
  assign hit_drv0 = (idx == fcor_pkg::IDX_DRV0);

  // ==========================================================
  // Bus handshake: one wait state, ack dropped after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // ==========================================================
  // Option control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      option_reg <= fcor_pkg::RST_OPTION;
    end else if (wr_en && idx == fcor_pkg::IDX_OPTION) begin
      option_reg <= wb_dat_i[7:0] & fcor_pkg::MASK_OPTION;
    end
  end

  // ==========================================================
  // Drive type store, all fields kept, upper two spare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      type_reg <= fcor_pkg::RST_TYPE;
    end else if (wr_en && idx == fcor_pkg::IDX_TYPE) begin
      type_reg <= wb_dat_i[7:0] & fcor_pkg::MASK_TYPE;
    end
  end

  // ==========================================================
  // Drive-0 configuration, bits 2, 5, 7 never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv0_reg <= fcor_pkg::RST_DRV0;
    end else if (wr_en && idx == fcor_pkg::IDX_DRV0) begin
      drv0_reg <= wb_dat_i[7:0] & fcor_pkg::MASK_DRV0;
    end
  end

  // ==========================================================
  // Read mux; unmapped indices and 0xF3 read zero
  always_comb begin
    unique case (idx)
      fcor_pkg::IDX_OPTION: rdata_next = option_reg;
      fcor_pkg::IDX_TYPE: rdata_next = type_reg;
      fcor_pkg::IDX_ZERO: rdata_next = 8'h00;
      fcor_pkg::IDX_DRV0: rdata_next = drv0_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else if (req && !wb_we_i) begin
      rdata_reg <= {24'h000000, rdata_next};
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ==========================================================
  // Drive-0 and drive B outputs, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive0_cfg_o <= '0;
      drive_b_type_o <= fcor_pkg::RST_TYPE[fcor_pkg::TYP_B_LO +: 2];
    end else begin
      drive0_cfg_o.drive_type <= drv0_reg[fcor_pkg::D0_TYPE_LO +: 2];
      drive0_cfg_o.rate_table <= drv0_reg[fcor_pkg::D0_RATE_LO +: 2];
      drive0_cfg_o.precomp_disable <= drv0_reg[fcor_pkg::D0_PRECOMP];
      drive_b_type_o <= type_reg[fcor_pkg::TYP_B_LO +: 2];
    end
  end

  // ==========================================================
  // Write-protect merge on both pin paths
  fcor_wp_merge u_wp_fdd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .force_wp_i(option_reg[fcor_pkg::OPT_FWP]),
    .disable_wp_i(disable_wp_i),
    .pins_i(fdd_pins_i),
    .wp_o(core_wp_int)
  );

  // Parallel-port path sees the same forced option
  fcor_wp_merge u_wp_pport (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .force_wp_i(option_reg[fcor_pkg::OPT_FWP]),
    .disable_wp_i(disable_wp_i),
    .pins_i(pport_pins_i),
    .wp_o(pport_wp_o)
  );

  // Status bit mirrors the core's view
  assign core_wp_o = core_wp_int;
  assign status_register_a_wp_o = core_wp_int;

  fcor_density u_density (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(option_reg[fcor_pkg::OPT_DENS_LO +: 2]),
    .core_density_i(core_density_i),
    .density_o(density_o)
  );

  // ==========================================================
  // Checks
  // Every property watches what this block drives; the reset-value checks
  // carry no disable so that they see the reset edge itself
  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  chk_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  chk_zero_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && idx == fcor_pkg::IDX_ZERO) |=> (wb_dat_o == 32'h00000000))
    else $error("reserved register read nonzero");
  chk_drv0_zero_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_drv0)
    |=> ((wb_dat_o[2] == 1'b0) && (wb_dat_o[5] == 1'b0) && (wb_dat_o[7] == 1'b0)))
    else $error("drive-0 read-only bit read as one");
  chk_drv0_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && idx == fcor_pkg::IDX_DRV0)
    |=> (drv0_reg == ($past(wb_dat_i[7:0]) & fcor_pkg::MASK_DRV0)))
    else $error("drive-0 write not stored");
  chk_precomp_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 drive0_cfg_o.precomp_disable == $past(drv0_reg[fcor_pkg::D0_PRECOMP]))
    else $error("precompensation disable not following register");
  chk_rate_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 drive0_cfg_o.rate_table == $past(drv0_reg[4:3]))
    else $error("rate table not following register");
  chk_pport_force: assert property (@(posedge clk_i) disable iff (rst_i)
    (option_reg[0] && !pport_pins_i.drive1_select_n) |=> pport_wp_o)
    else $error("parallel-port path not forced");

  // ==========================================================
  // Reset values, checked with no reset disable
  chk_opt_reset: assert property (@(posedge clk_i)
    rst_i |=> (option_reg == fcor_pkg::RST_OPTION))
    else $error("option register not cleared by reset");
  chk_type_reset: assert property (@(posedge clk_i)
    rst_i |=> (type_reg == fcor_pkg::RST_TYPE))
    else $error("type store not preset by reset");
  chk_drv0_reset: assert property (@(posedge clk_i)
    rst_i |=> (drv0_reg == fcor_pkg::RST_DRV0))
    else $error("drive-0 register not cleared by reset");
  chk_bus_reset: assert property (@(posedge clk_i)
    rst_i |=> (!wb_ack_o && (wb_dat_o == 32'h00000000)))
    else $error("bus outputs active after reset");

  // ==========================================================
  // Read path: data stands only in the ack cycle of a read
  chk_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> (wb_dat_o == 32'h00000000))
    else $error("read data driven outside ack cycle");
  chk_dat_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_dat_o[31:8] == 24'h000000))
    else $error("upper read data bits set");
  chk_ack_request: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  chk_write_dat: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i) |=> (wb_dat_o == 32'h00000000))
    else $error("read data driven on a write");
  chk_opt_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_option) |=> (wb_dat_o[7:0] == $past(option_reg)))
    else $error("option readback differs from stored value");
  chk_type_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_type) |=> (wb_dat_o[7:0] == $past(type_reg)))
    else $error("type store readback differs from stored value");
  chk_drv0_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_drv0) |=> (wb_dat_o[7:0] == $past(drv0_reg)))
    else $error("drive-0 readback differs from stored value");
  chk_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && !hit_option && !hit_type && !hit_drv0)
    |=> (wb_dat_o == 32'h00000000))
    else $error("unmapped or reserved index read nonzero");

  // ==========================================================
  // Write path: masks, byte select and the read-only index
  chk_opt_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && hit_option)
    |=> (option_reg == ($past(wb_dat_i[7:0]) & fcor_pkg::MASK_OPTION)))
    else $error("option write not stored");
  chk_type_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && hit_type) |=> (type_reg == $past(wb_dat_i[7:0])))
    else $error("type store write not kept in full");
  chk_opt_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    (option_reg[7:4] == 4'h0))
    else $error("option reserved bits set");
  chk_sel_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0])
    |=> ($stable(option_reg) && $stable(type_reg) && $stable(drv0_reg)))
    else $error("write with low byte deselected changed a register");
  chk_zero_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && wb_we_i && hit_zero)
    |=> ($stable(option_reg) && $stable(type_reg) && $stable(drv0_reg)))
    else $error("write to read-only index changed a register");

  // ==========================================================
  // Drive outputs follow their fields one edge later
  chk_btype_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 drive_b_type_o == $past(type_reg[fcor_pkg::TYP_B_LO +: 2]))
    else $error("drive B type not following register");
  chk_dtype_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 drive0_cfg_o.drive_type == $past(drv0_reg[fcor_pkg::D0_TYPE_LO +: 2]))
    else $error("drive-0 type not following register");
  chk_precomp_on: assert property (@(posedge clk_i) disable iff (rst_i)
    !drv0_reg[fcor_pkg::D0_PRECOMP] |=> !drive0_cfg_o.precomp_disable)
    else $error("precompensation not applied with bit clear");

  // ==========================================================
  // Write-protect on both pin paths; pins are active low
  chk_status_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
    (status_register_a_wp_o == core_wp_o))
    else $error("status bit differs from core write-protect");
  chk_fdd_force_d1: assert property (@(posedge clk_i) disable iff (rst_i)
    (option_reg[fcor_pkg::OPT_FWP] && !fdd_pins_i.drive1_select_n) |=> core_wp_o)
    else $error("forced write-protect missing on drive 1");
  chk_fdd_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    !fdd_pins_i.write_protect_in_n |=> core_wp_o)
    else $error("write-protect pin not passed to core");
  chk_disable_wp: assert property (@(posedge clk_i) disable iff (rst_i)
    disable_wp_i |=> (core_wp_o && pport_wp_o))
    else $error("device-disable protect not applied");
  chk_force_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (!option_reg[fcor_pkg::OPT_FWP] && fdd_pins_i.write_protect_in_n && !disable_wp_i)
    |=> !core_wp_o)
    else $error("write-protect active with force off");
  chk_pport_d0: assert property (@(posedge clk_i) disable iff (rst_i)
    (option_reg[fcor_pkg::OPT_FWP] && !pport_pins_i.drive0_select_n) |=> pport_wp_o)
    else $error("parallel-port drive 0 not forced");
  chk_pport_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    !pport_pins_i.write_protect_in_n |=> pport_wp_o)
    else $error("parallel-port write-protect pin not passed");
  chk_pport_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (!option_reg[fcor_pkg::OPT_FWP] && pport_pins_i.write_protect_in_n && !disable_wp_i)
    |=> !pport_wp_o)
    else $error("parallel-port write-protect active with force off");

  // ==========================================================
  // Density override
  chk_dens_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (option_reg[fcor_pkg::OPT_DENS_LO +: 2] == fcor_pkg::DENS_LOW) |=> !density_o)
    else $error("density not forced low");

  cov_wr_option: cover property (@(posedge clk_i) wr_en && idx == fcor_pkg::IDX_OPTION);
  cov_rd_drv0: cover property (@(posedge clk_i) req && !wb_we_i && idx == fcor_pkg::IDX_DRV0);
  cov_forced_wp: cover property (@(posedge clk_i) option_reg[0] && core_wp_o);
  cov_dens_low: cover property (@(posedge clk_i) option_reg[3:2] == fcor_pkg::DENS_LOW);
  cov_sel_off: cover property (@(posedge clk_i) wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0]);

endmodule // fcor_regs

// ### fcor_pkg.sv
/*
  Package for the floppy configuration option registers: register indices,
  field positions, reset values and the carrier structs.
  Assumes a Wishbone classic slave with 32-bit data and word addressing.
*/
package fcor_pkg;

  // ==========================================================
  // Register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_OPTION = 8'hF1;
  localparam logic [7:0] IDX_TYPE = 8'hF2;
  localparam logic [7:0] IDX_ZERO = 8'hF3;
  localparam logic [7:0] IDX_DRV0 = 8'hF4;
  localparam int ADDR_W = 10;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_OPTION = 8'h00;
  localparam logic [7:0] RST_TYPE = 8'hFF;
  localparam logic [7:0] RST_DRV0 = 8'h00;

  // ==========================================================
  // Writable bit masks
  localparam logic [7:0] MASK_OPTION = 8'h0F;
  localparam logic [7:0] MASK_TYPE = 8'hFF;
  localparam logic [7:0] MASK_DRV0 = 8'h5B;

  // ==========================================================
  // Field positions
  localparam int OPT_FWP = 0;
  localparam int OPT_DENS_LO = 2;
  localparam int TYP_B_LO = 2;
  localparam int D0_TYPE_LO = 0;
  localparam int D0_RATE_LO = 3;
  localparam int D0_PRECOMP = 6;

  // Density select codes
  localparam logic [1:0] DENS_HIGH = 2'h2;
  localparam logic [1:0] DENS_LOW = 2'h3;

  typedef struct packed {
    logic drive0_select_n;
    logic drive1_select_n;
    logic write_protect_in_n;
  } fcor_drive_pins_t;

  typedef struct packed {
    logic [1:0] drive_type;
    logic [1:0] rate_table;
    logic precomp_disable;
  } fcor_drive0_cfg_t;

endpackage

// ### fcor_wp_merge.sv
/*
  Write-protect merge for one floppy pin path (dedicated or parallel-port).
  Assumes active-low pins synchronous to clk_i; output is registered.
*/
`timescale 1ns/1ps
module fcor_wp_merge (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset, high
  input wire logic force_wp_i, // Forced write-protect option
  input wire logic disable_wp_i, // Device-disable write-protect bit
  input fcor_pkg::fcor_drive_pins_t pins_i, // Drive pins
  output logic wp_o // Write protect active high
);
  logic wp_next;

  // ==========================================================
  // Selected drive gated with force, OR pin, OR disable bit
  always_comb begin
    wp_next = (~pins_i.drive0_select_n & force_wp_i)
            | (~pins_i.drive1_select_n & force_wp_i)
            | ~pins_i.write_protect_in_n
            | disable_wp_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_o <= 1'b0;
    end else begin
      wp_o <= wp_next;
    end
  end

  chk_wp_force_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    (force_wp_i && !pins_i.drive0_select_n) |=> wp_o)
    else $error("forced write-protect not applied");
  chk_wp_idle_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (!disable_wp_i && pins_i.write_protect_in_n && pins_i.drive0_select_n
     && pins_i.drive1_select_n) |=> !wp_o)
    else $error("write-protect active without cause");
endmodule // fcor_wp_merge

// ### fcor_density.sv
/*
  Density output override driven by the two-bit density select field.
  Assumes the core's own density request is synchronous to clk_i.
*/
`timescale 1ns/1ps
module fcor_density (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset, high
  input wire logic [1:0] sel_i, // Density select field
  input wire logic core_density_i, // Core's own density level
  output logic density_o // Density to drive
);
  logic density_next;

  always_comb begin
    unique case (sel_i)
      fcor_pkg::DENS_HIGH: density_next = 1'b1;
      fcor_pkg::DENS_LOW: density_next = 1'b0;
      default: density_next = core_density_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      density_o <= 1'b0;
    end else begin
      density_o <= density_next;
    end
  end

  chk_dens_forced: assert property (@(posedge clk_i) disable iff (rst_i)
    (sel_i == fcor_pkg::DENS_HIGH) |=> density_o)
    else $error("density not forced high");
  chk_dens_normal: assert property (@(posedge clk_i) disable iff (rst_i)
    (!sel_i[1]) |=> (density_o == $past(core_density_i)))
    else $error("density not passed through");
endmodule // fcor_density

// ### fcor_drive_model.sv
/*
  Far-side model: drive interface pins of both paths and the core density level.
  Assumes the bench sets cmd_i after a rising edge of clk_i.
*/
`timescale 1ns/1ps
module fcor_drive_model (
  input wire logic clk_i, // Clock
  input wire logic [6:0] cmd_i, // Density, parallel pins, dedicated pins
  output fcor_pkg::fcor_drive_pins_t fdd_pins_o, // Dedicated drive pins
  output fcor_pkg::fcor_drive_pins_t pport_pins_o, // Parallel-port floppy pins
  output logic core_density_o // Core density request
);
  // ==========================================================
  // Pins
  // Idle drive: nothing selected, no protect, so forcing has no effect until a drive is selected
  initial begin
    fdd_pins_o = 3'h7;
    pport_pins_o = 3'h7;
    core_density_o = 1'b0;
  end
  always @(posedge clk_i) begin
    fdd_pins_o <= cmd_i[2:0];
    pport_pins_o <= cmd_i[5:3];
    core_density_o <= cmd_i[6];
  end
endmodule // fcor_drive_model

// ### fcor_regs_test.sv
/*
  Self-checking bench for the floppy option registers over Wishbone classic.
  Assumes the far-side pins come from fcor_drive_model.
*/
`timescale 1ns/1ps
module fcor_regs_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, disable_wp_i = 1'b0;
  logic [fcor_pkg::ADDR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [6:0] cmd = 7'h3F;
  logic wb_ack_o, core_wp_o, pport_wp_o, status_a_wp, density_o, core_density;
  logic [1:0] drive_b_type_o;
  fcor_pkg::fcor_drive_pins_t fdd_pins, pport_pins;
  fcor_pkg::fcor_drive0_cfg_t drive0_cfg_o;
  int err_count = 0, n_compared = 0;
  always #10 clk_i = ~clk_i;
  fcor_drive_model i_model (.clk_i(clk_i), .cmd_i(cmd), .fdd_pins_o(fdd_pins),
    .pport_pins_o(pport_pins), .core_density_o(core_density));
  fcor_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .disable_wp_i(disable_wp_i),
    .fdd_pins_i(fdd_pins), .pport_pins_i(pport_pins), .core_density_i(core_density),
    .core_wp_o(core_wp_o), .pport_wp_o(pport_wp_o), .status_register_a_wp_o(status_a_wp),
    .density_o(density_o), .drive_b_type_o(drive_b_type_o), .drive0_cfg_o(drive0_cfg_o));
  // ==========================================================
  // Reporting
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ==========================================================
  // Bus cycle: one request held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
    input logic s0);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= {3'h0, s0};
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic run_reset_and_masks();
    wb(0, fcor_pkg::IDX_OPTION, 0, 1); chk("opt rst", rd, 32'h00);
    wb(0, fcor_pkg::IDX_TYPE, 0, 1); chk("type rst", rd, 32'hFF);
    chk("b type rst", drive_b_type_o, 32'h3);
    wb(1, fcor_pkg::IDX_ZERO, 8'hFF, 1);
    wb(0, fcor_pkg::IDX_ZERO, 0, 1); chk("zero reg", rd, 32'h00);
    wb(0, 8'hF8, 0, 1); chk("unmapped", rd, 32'h00);
    wb(1, fcor_pkg::IDX_DRV0, 8'hFF, 1);
    wb(0, fcor_pkg::IDX_DRV0, 0, 1); chk("drv0 ro bits", rd, 32'h5B);
    settle();
    chk("drv0 cfg", drive0_cfg_o, 32'h1F);
    wb(1, fcor_pkg::IDX_DRV0, 8'h08, 1);
    wb(1, fcor_pkg::IDX_DRV0, 8'h13, 0);
    settle();
    chk("drv0 sel0 off", drive0_cfg_o, 32'h02);
    wb(1, fcor_pkg::IDX_TYPE, 8'hA6, 1);
    wb(0, fcor_pkg::IDX_TYPE, 0, 1); chk("type rdbk", rd, 32'hA6);
    settle();
    chk("b type", drive_b_type_o, 32'h1);
  endtask
  task automatic run_wp();
    logic [2:0] p;
    logic ef, ep;
    for (int k = 0; k < 32; k++) begin
      p = k[2:0];
      wb(1, fcor_pkg::IDX_OPTION, {7'h0, k[3]}, 1);
      cmd <= {1'b0, ~p, p};
      disable_wp_i <= k[4];
      settle();
      ef = (k[3] & (!p[2] | !p[1])) | !p[0] | k[4];
      ep = (k[3] & (p[2] | p[1])) | p[0] | k[4];
      chk("core wp", core_wp_o, ef);
      chk("status wp", status_a_wp, ef);
      chk("pport wp", pport_wp_o, ep);
    end
  endtask
  task automatic run_density();
    for (int k = 0; k < 8; k++) begin
      wb(1, fcor_pkg::IDX_OPTION, {4'h0, k[2:1], 2'h0}, 1);
      cmd <= {k[0], 6'h3F};
      settle();
      chk("density", density_o, k[2] ? !k[1] : k[0]);
    end
  endtask
  task automatic run_mid_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, fcor_pkg::IDX_TYPE, 0, 1); chk("type rst2", rd, 32'hFF);
    wb(0, fcor_pkg::IDX_DRV0, 0, 1); chk("drv0 rst2", rd, 32'h00);
    chk("cfg rst2", drive0_cfg_o, 32'h00);
    chk("b type rst2", drive_b_type_o, 32'h3);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    run_reset_and_masks();
    run_wp();
    run_density();
    run_mid_reset();
    end_of_test();
  end
endmodule // fcor_regs_test
